/* File: testbench/ufft_peer.sv */
// Remote serial peer that captures transmitted frames and sends frames back.
`timescale 1ns/10ps
module ufft_peer
(
  input  wire logic        i_clk,
  input  wire logic        i_txd,
  input  wire logic        i_oe,
  input  wire logic        i_sync,
  input  wire logic        i_xck_run,
  input  wire logic [4:0]  i_per,
  input  wire logic [3:0]  i_nb,
  output logic             o_rxd,
  output logic             o_xck,
  output logic      [12:0] o_bits,
  output int               o_nf,
  output time              o_t_prev,
  output time              o_t_last
);
  logic line;

  // A released pin is pulled up, so the line then reads the idle level.
  assign line = i_oe ? i_txd : 1'b1;

  // The transfer clock starts a fixed time after the request, so the start bit is whole.
  initial
  begin
    o_xck = 1'b0;
    forever
    begin
      wait (i_xck_run);
      #83 o_xck = 1'b1;
      #80 o_xck = 1'b0;
      while (i_xck_run)
      begin
        #80 o_xck = 1'b1;
        #80 o_xck = 1'b0;
      end
    end
  end

  // Captures each frame bit by bit, at mid-bit or on a rising transfer clock.
  initial
  begin
    o_nf = 0;
    o_t_last = 0;
    forever
    begin
      @(negedge line);
      o_bits = '0;
      o_t_prev = o_t_last;
      o_t_last = $time;
      for (int i = 0; i < i_nb; i++)
      begin
        if (i_sync)
          @(posedge o_xck);
        else if (i == 0)
          #(i_per * 10 + 5);
        else
          #(i_per * 20);
        o_bits[i] = line;
      end
      o_nf++;
    end
  end

  // Sends one eight-bit frame with chosen stop levels, sixteen clocks a bit.
  task automatic send_rx(input logic [7:0] d, input logic s1, input logic s2);
    logic [10:0] f;
    f = {s2, s1, d, 1'b0};
    for (int i = 0; i < 11; i++)
    begin
      @(posedge i_clk);
      o_rxd <= f[i];
      repeat (15) @(posedge i_clk);
    end
    @(posedge i_clk);
    o_rxd <= 1'b1;
  endtask

  // The receive line idles high.
  initial o_rxd = 1'b1;
endmodule

/* File: testbench/ufft_top_tb.sv */
// Self-checking bench for the serial frame transmitter.
`timescale 1ns/10ps
module ufft_top_tb;
  import ufft_pkg::*;
  typedef struct {
    logic [2:0] csz;
    logic [1:0] par;
    logic       stop2, dbl, sync, ninth;
    logic [7:0] d;
    logic [3:0] nb;
  } ufft_row_t;
  logic        clk, rst, wr_s, rd_s, xck, rxd, txd, oe, xrun, sync;
  logic [2:0]  addr;
  logic [7:0]  wdata, rdata, q;
  logic [4:0]  per;
  logic [3:0]  nb;
  logic [12:0] bits;
  int          nf, n0, err_total, samples_checked;
  time         t_prev, t_last;
  ufft_row_t   r;
  // Format, data and the frame length on the wire that they should give.
  ufft_row_t   rows [7] = '{'{3'h0, 2'h0, 0, 0, 0, 0, 8'hff, 4'd7},
    '{3'h1, 2'h2, 1, 0, 0, 0, 8'h2d, 4'd10}, '{3'h2, 2'h3, 0, 1, 0, 0, 8'h5a, 4'd10},
    '{3'h3, 2'h2, 0, 0, 1, 0, 8'ha7, 4'd11}, '{3'h7, 2'h3, 1, 0, 0, 1, 8'h3c, 4'd13},
    '{3'h3, 2'h0, 1, 0, 0, 0, 8'h81, 4'd11}, '{3'h3, 2'h1, 0, 0, 0, 0, 8'hc3, 4'd10}};

  ufft_top dut_u (.i_core_clk(clk), .i_rst(rst), .i_addr(addr), .i_wdata(wdata),
    .i_wr(wr_s), .i_rd(rd_s), .o_rdata(rdata), .i_xck(xck), .i_rxd(rxd),
    .o_txd(txd), .o_txd_oe(oe));
  ufft_peer peer_u (.i_clk(clk), .i_txd(txd), .i_oe(oe), .i_sync(sync),
    .i_xck_run(xrun), .i_per(per), .i_nb(nb), .o_rxd(rxd), .o_xck(xck),
    .o_bits(bits), .o_nf(nf), .o_t_prev(t_prev), .o_t_last(t_last));

  // The core clock toggles every half period.
  always #10 clk = ~clk;

  // Builds the expected wire bits, first bit in bit zero.
  function automatic logic [12:0] exp_frame(input ufft_row_t x);
    logic [8:0]  d;
    logic [12:0] v;
    int          nd;
    nd = (x.csz == 3'h7) ? 9 : x.csz + 5;
    d = {x.ninth, x.d} & 9'((1 << nd) - 1);
    v = {d, 1'b0};
    if (x.par[1])
    begin
      v[nd + 1] = ^d ^ x.par[0];
      nd++;
    end
    v[nd + 1] = 1'b1;
    if (x.stop2)
      v[nd + 2] = 1'b1;
    return v;
  endfunction

  task automatic wr(input logic [2:0] a, input logic [7:0] d);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    wr_s <= 1'b1;
    @(posedge clk);
    wr_s <= 1'b0;
  endtask

  task automatic rd(input logic [2:0] a, output logic [7:0] v);
    @(posedge clk);
    addr <= a;
    rd_s <= 1'b1;
    @(posedge clk);
    rd_s <= 1'b0;
    #1;
    v = rdata;
  endtask

  task automatic chk(input logic [12:0] seen, input logic [12:0] exp);
    samples_checked++;
    if (seen !== exp)
    begin
      err_total++;
      $display("[FAIL] %0t ns: seen %h, expected %h", $time, seen, exp);
    end
  endtask

  task automatic final_report;
    $display("Comparisons %0d, mismatches %0d", samples_checked, err_total);
    if (err_total == 0 && samples_checked > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask

  // Waits, within a bound, until the peer has captured n frames.
  task automatic wait_frames(input int n);
    int c;
    c = 0;
    while (nf < n && c < 6000)
    begin
      @(posedge clk);
      c++;
    end
    if (nf < n)
    begin
      err_total++;
      $display("[FAIL] %0t ns: no frame", $time);
      final_report();
    end
  endtask

  // Main sequence: table of formats, then back-to-back, frame error, baud divisor and reset.
  initial
  begin
    clk = 0;
    rst = 1;
    addr = '0;
    wdata = '0;
    wr_s = 0;
    rd_s = 0;
    xrun = 0;
    sync = 0;
    per = 5'd16;
    nb = 4'd10;
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    foreach (rows[i])
    begin
      r = rows[i];
      per = r.dbl ? 5'd8 : 5'd16;
      nb = r.nb;
      sync = r.sync;
      wr(OFF_CTRL_C, {1'b0, r.sync, r.par, r.stop2, r.csz});
      wr(OFF_CTRL_A, {6'h10, r.dbl, 1'b0});
      wr(OFF_CTRL_B, {7'h04, r.ninth});
      n0 = nf;
      wr(OFF_DATA, r.d);
      xrun = r.sync;
      wait_frames(n0 + 1);
      chk(bits, exp_frame(r));
      chk(13'(oe), 13'h1);
      repeat (24) @(posedge clk);
      xrun = 0;
      chk(13'(txd), 13'h1);
      rd(OFF_CTRL_A, q);
      chk(13'(q), {5'h0, 8'h60 | (8'(r.dbl) << 1)});
      $display("Format row %0d finished", i);
    end
    per = 5'd16;
    nb = 4'd10;
    sync = 0;
    wr(OFF_CTRL_C, 8'h03);
    wr(OFF_CTRL_A, 8'h40);
    n0 = nf;
    wr(OFF_DATA, 8'h4b);
    wr(OFF_DATA, 8'hd2);
    rd(OFF_CTRL_A, q);
    chk(13'(q), 13'h00);
    wr(OFF_CTRL_B, 8'h00);
    wait_frames(n0 + 1);
    chk(13'(oe), 13'h1);
    wait_frames(n0 + 2);
    chk(bits, {3'h0, 1'b1, 8'hd2, 1'b0});
    chk(13'((t_last - t_prev) / 20), 13'd160);
    repeat (24) @(posedge clk);
    chk(13'(oe), 13'h0);
    $display("Back-to-back test finished");
    peer_u.send_rx(8'h55, 1'b0, 1'b1);
    repeat (4) @(posedge clk);
    rd(OFF_CTRL_A, q);
    chk(13'(q[A_FE]), 13'h1);
    peer_u.send_rx(8'h55, 1'b1, 1'b0);
    repeat (4) @(posedge clk);
    rd(OFF_CTRL_A, q);
    chk(13'(q[A_FE]), 13'h0);
    $display("Frame error test finished");
    wr(OFF_CTRL_B, 8'h08);
    wr(OFF_BAUD_LO, 8'h01);
    wr(OFF_CTRL_A, 8'h42);
    n0 = nf;
    wr(OFF_DATA, 8'h96);
    wait_frames(n0 + 1);
    chk(bits, {3'h0, 1'b1, 8'h96, 1'b0});
    rd(OFF_BAUD_LO, q);
    chk(13'(q), 13'h01);
    $display("Baud divisor test finished");
    @(posedge clk);
    rst <= 1'b1;
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    #1;
    chk({11'h0, oe, txd}, 13'h1);
    rd(OFF_CTRL_C, q);
    chk(13'(q), 13'h03);
    rd(OFF_CTRL_A, q);
    chk(13'(q), 13'h20);
    wr(3'h7, 8'hff);
    rd(3'h7, q);
    chk(13'(q), 13'h0);
    rd(3'h6, q);
    chk(13'(q), 13'h0);
    $display("Reset test finished");
    final_report();
  end
endmodule

/* File: verilog/ufft_pkg.sv */
// Constants, field layouts and types shared by the serial frame transmitter.
//
// Overview of operation
// - One start, 5-9 data, parity option, 1-2 stops.
// - Start bit first, then data LSB first.
// - Parity bit follows last data bit.
// - Next frame back to back or idle high.
// - Start bit low, stop bits high.
// - Transmitter and receiver share one format setting.
// - Size, parity and stop fields pick format.
// - Only first stop bit checked for frame error.
// - Parity is data xor, inverted when odd.
// - Enable makes block drive serial output pin.
// - Synchronous mode shifts on transfer clock pin.
// - Data buffer write loads buffer, starts sending.
// - Buffer enters shifter when idle or after stop.
// - Frame sent at divisor, double-speed or external rate.
// - Unused upper data bits are ignored.
// - Empty flag shows buffer state, write clears.
// - Complete flag sets after frame, buffer empty.
// - Disable waits for all pending data first.
// - Upper parity-mode bit enables parity.
package ufft_pkg;
  localparam int          AW          = 3;
  localparam int          DW          = 8;
  localparam int          BAUD_W      = 12;
  // Register offsets.
  localparam logic [2:0]  OFF_DATA    = 3'h0;
  localparam logic [2:0]  OFF_CTRL_A  = 3'h1;
  localparam logic [2:0]  OFF_CTRL_B  = 3'h2;
  localparam logic [2:0]  OFF_CTRL_C  = 3'h3;
  localparam logic [2:0]  OFF_BAUD_LO = 3'h4;
  localparam logic [2:0]  OFF_BAUD_HI = 3'h5;
  // Field positions in ctrl_reg_a.
  localparam int          A_DBL       = 1;
  localparam int          A_FE        = 4;
  localparam int          A_EMPTY     = 5;
  localparam int          A_TXC       = 6;
  // Field positions in ctrl_reg_b.
  localparam int          B_NINTH     = 0;
  localparam int          B_TX_ENABLE_BIT      = 3;
  // Field positions in ctrl_reg_c.
  localparam int          C_CSZ       = 0;
  localparam int          C_STOP      = 3;
  localparam int          C_PAR       = 4;
  localparam int          C_SYNC      = 6;
  // Reset values and codes.
  localparam logic [6:0]  CFG_RST     = 7'h03;
  localparam logic [2:0]  CSZ_NINE    = 3'h7;
  localparam logic [3:0]  BITS_BASE   = 4'h5;
  localparam logic [3:0]  BITS_NINE   = 4'h9;
  localparam logic [3:0]  BITS_RSVD   = 4'h8;
  // Prescaler end values for normal and double speed, and mid-bit points.
  localparam logic [3:0]  PRE_NORM    = 4'hf;
  localparam logic [3:0]  PRE_DBL     = 4'h7;
  localparam logic [3:0]  MID_NORM    = 4'h7;
  localparam logic [3:0]  MID_DBL     = 4'h3;
  // Shared frame format, one copy for both directions.
  typedef struct packed {
    logic       sync;
    logic [1:0] par;
    logic       stop2;
    logic [2:0] csz;
  } ufft_cfg_t;
  // Transmit states, Gray coded along the frame.
  typedef enum logic [2:0] {
    TX_IDLE  = 3'b000,
    TX_START = 3'b001,
    TX_DATA  = 3'b011,
    TX_PAR   = 3'b010,
    TX_STOP1 = 3'b110,
    TX_STOP2 = 3'b111
  } ufft_tx_st_t;
endpackage

/* File: verilog/ufft_top.sv */
// Serial frame transmitter with shared format registers and frame-error check.
//
// Our own choices: the strobed register port and the register offsets.
`timescale 1ns/10ps
module ufft_top
  import ufft_pkg::*;
#(
  parameter int BAUD_WIDTH = BAUD_W
)
(
  input  wire logic          i_core_clk,
  input  wire logic          i_rst,
  input  wire logic [AW-1:0] i_addr,
  input  wire logic [DW-1:0] i_wdata,
  input  wire logic          i_wr,
  input  wire logic          i_rd,
  output logic      [DW-1:0] o_rdata,
  input  wire logic          i_xck,
  input  wire logic          i_rxd,
  output logic               o_txd,
  output logic               o_txd_oe
);

  // Register state.
  ufft_cfg_t               cfg_q;
  logic                    dbl_q;
  logic                    tx_enable_bit_q;
  logic                    ninth_q;
  logic [BAUD_WIDTH-1:0]   div_q;
  logic [BAUD_WIDTH-1:0]   bcnt_q;
  logic [8:0]              buf_q;
  logic                    full_q;
  logic                    txc_q;
  logic                    fe_q;
  logic                    on_q;
  ufft_tx_st_t             st_q;
  logic [8:0]              sh_q;
  logic [3:0]              idx_q;
  logic                    par_q;
  logic [3:0]              pre_q;
  logic [2:0]              xs_q;
  logic [2:0]              rs_q;
  logic                    xf_q;
  logic                    rf_q;
  logic                    rrun_q;
  logic [3:0]              rpre_q;
  logic [3:0]              ridx_q;

  // Bus decode.
  wire wr_data = i_wr && (i_addr == OFF_DATA);
  wire wr_a    = i_wr && (i_addr == OFF_CTRL_A);
  wire wr_b    = i_wr && (i_addr == OFF_CTRL_B);
  wire wr_c    = i_wr && (i_addr == OFF_CTRL_C);
  wire wr_lo   = i_wr && (i_addr == OFF_BAUD_LO);
  wire wr_hi   = i_wr && (i_addr == OFF_BAUD_HI);

  // Data bit count from the size code; reserved codes fall back to eight.
  wire [3:0] nbits = (cfg_q.csz[2] == 1'b0) ? BITS_BASE + {2'b00, cfg_q.csz[1:0]}
                   : (cfg_q.csz == CSZ_NINE) ? BITS_NINE : BITS_RSVD;
  wire       par_en  = cfg_q.par[1];
  wire       par_odd = cfg_q.par[0];

  // Write data with the unused upper bits masked and the ninth bit from control.
  wire [8:0] mask   = 9'h1ff >> (4'h9 - nbits);
  wire [8:0] wr_chr = {ninth_q, i_wdata} & mask;

  // Baud tick and transmit bit enable; the prescaler restarts when a frame starts from idle.
  wire       tick     = (bcnt_q == '0);
  wire [3:0] pre_end  = dbl_q ? PRE_DBL : PRE_NORM;
  wire [3:0] mid      = dbl_q ? MID_DBL : MID_NORM;
  wire       xck_rise = xs_q[1] && xs_q[2] && !xf_q;
  wire       xck_fall = !xs_q[1] && !xs_q[2] && xf_q;
  wire       bit_en   = cfg_q.sync ? xck_rise : (tick && (pre_q == pre_end));

  // Frame sequencing terms.
  wire last_data = (idx_q == nbits - 4'h1);
  wire stop_end  = bit_en && (((st_q == TX_STOP1) && !cfg_q.stop2) || (st_q == TX_STOP2));
  wire load_idle = (st_q == TX_IDLE) && full_q && on_q;
  wire load_chain = stop_end && full_q && on_q;
  wire load      = load_idle || load_chain;
  wire chr_par   = ^buf_q ^ par_odd;

  // Next transmit state.
  ufft_tx_st_t st_d;
  always_comb
  begin
    st_d = st_q;
    case (st_q)
      TX_IDLE:  if (load_idle) st_d = TX_START;
      TX_START: if (bit_en) st_d = TX_DATA;
      TX_DATA:  if (bit_en && last_data) st_d = par_en ? TX_PAR : TX_STOP1;
      TX_PAR:   if (bit_en) st_d = TX_STOP1;
      TX_STOP1: if (bit_en) st_d = cfg_q.stop2 ? TX_STOP2 : (load_chain ? TX_START : TX_IDLE);
      TX_STOP2: if (bit_en) st_d = load_chain ? TX_START : TX_IDLE;
      default:  st_d = TX_IDLE;
    endcase
  end

  // Line level for each state.
  logic txd_d;
  always_comb
  begin
    case (st_q)
      TX_START: txd_d = 1'b0;
      TX_DATA:  txd_d = sh_q[0];
      TX_PAR:   txd_d = par_q;
      default:  txd_d = 1'b1;
    endcase
  end

  // Register writes shared by both directions.
  always_ff @(posedge i_core_clk)
  begin
    if (i_rst)
    begin
      cfg_q   <= CFG_RST;
      dbl_q   <= 1'b0;
      tx_enable_bit_q  <= 1'b0;
      ninth_q <= 1'b0;
      div_q   <= '0;
    end
    else
    begin
      if (wr_a) dbl_q <= i_wdata[A_DBL];
      if (wr_b) tx_enable_bit_q <= i_wdata[B_TX_ENABLE_BIT];
      if (wr_b) ninth_q <= i_wdata[B_NINTH];
      if (wr_c) cfg_q <= ufft_cfg_t'(i_wdata[6:0]);
      if (wr_lo) div_q[7:0] <= i_wdata;
      if (wr_hi) div_q[BAUD_WIDTH-1:8] <= i_wdata[BAUD_WIDTH-9:0];
    end
  end

  // Baud down-counter, reloaded at zero or on a low divisor write.
  always_ff @(posedge i_core_clk)
  begin
    if (i_rst) bcnt_q <= '0;
    else if (wr_lo) bcnt_q <= {div_q[BAUD_WIDTH-1:8], i_wdata};
    else if (tick) bcnt_q <= div_q;
    else bcnt_q <= bcnt_q - 1'b1;
  end

  // Transmit buffer and its flags; a new frame end wins over a clear.
  always_ff @(posedge i_core_clk)
  begin
    if (i_rst)
    begin
      buf_q  <= '0;
      full_q <= 1'b0;
      txc_q  <= 1'b0;
    end
    else
    begin
      if (wr_data)
        buf_q <= wr_chr;
      if (wr_data)
        full_q <= 1'b1;
      else if (load)
        full_q <= 1'b0;
      if (stop_end && !full_q)
        txc_q <= 1'b1;
      else if (wr_a && i_wdata[A_TXC])
        txc_q <= 1'b0;
    end
  end

  // Transmit enable holds until shifter and buffer are both drained.
  always_ff @(posedge i_core_clk)
  begin
    if (i_rst) on_q <= 1'b0;
    else if (tx_enable_bit_q) on_q <= 1'b1;
    else if ((st_q == TX_IDLE) && !full_q) on_q <= 1'b0;
  end

  // Shifter, data index and prescaler.
  always_ff @(posedge i_core_clk)
  begin
    if (i_rst)
    begin
      st_q  <= TX_IDLE;
      sh_q  <= '0;
      idx_q <= '0;
      par_q <= 1'b0;
      pre_q <= '0;
    end
    else
    begin
      st_q <= st_d;
      if (load_idle) pre_q <= '0;
      else if (tick) pre_q <= (pre_q == pre_end) ? 4'h0 : pre_q + 4'h1;
      if (load)
      begin
        sh_q  <= buf_q;
        par_q <= chr_par;
        idx_q <= '0;
      end
      else if (bit_en && (st_q == TX_DATA))
      begin
        sh_q  <= sh_q >> 1;
        idx_q <= idx_q + 4'h1;
      end
    end
  end

  // Pin outputs straight from flops.
  always_ff @(posedge i_core_clk)
  begin
    if (i_rst)
    begin
      o_txd    <= 1'b1;
      o_txd_oe <= 1'b0;
    end
    else
    begin
      o_txd    <= txd_d;
      o_txd_oe <= on_q;
    end
  end

  // Three-flop synchronisers; a level counts once the last two agree.
  always_ff @(posedge i_core_clk)
  begin
    if (i_rst)
    begin
      xs_q <= 3'h0;
      rs_q <= 3'h7;
      xf_q <= 1'b0;
      rf_q <= 1'b1;
    end
    else
    begin
      xs_q <= {xs_q[1:0], i_xck};
      rs_q <= {rs_q[1:0], i_rxd};
      if (xs_q[1] == xs_q[2]) xf_q <= xs_q[2];
      if (rs_q[1] == rs_q[2]) rf_q <= rs_q[2];
    end
  end

  // Receive framing check: sample mid-bit, judge only the first stop bit.
  wire [3:0] rlast   = nbits + {3'b000, par_en} + 4'h1;
  wire       rsample = cfg_q.sync ? xck_fall : (tick && (rpre_q == mid));
  wire       rstart  = !rrun_q && !rf_q;
  always_ff @(posedge i_core_clk)
  begin
    if (i_rst)
    begin
      rrun_q <= 1'b0;
      rpre_q <= '0;
      ridx_q <= '0;
      fe_q   <= 1'b0;
    end
    else
    begin
      if (rstart)
      begin
        rrun_q <= 1'b1;
        rpre_q <= '0;
        ridx_q <= '0;
      end
      else if (rrun_q)
      begin
        if (tick) rpre_q <= (rpre_q == pre_end) ? 4'h0 : rpre_q + 4'h1;
        if (rsample)
        begin
          ridx_q <= ridx_q + 4'h1;
          if ((ridx_q == 4'h0) && rf_q) rrun_q <= 1'b0;
          if (ridx_q == rlast)
          begin
            fe_q   <= !rf_q;
            rrun_q <= 1'b0;
          end
        end
      end
    end
  end

  // Read mux; read data stand in the cycle after the strobe.
  logic [DW-1:0] rd_mux;
  always_comb
  begin
    case (i_addr)
      OFF_DATA:    rd_mux = buf_q[7:0];
      OFF_CTRL_A:  rd_mux = {1'b0, txc_q, !full_q, fe_q, 2'b00, dbl_q, 1'b0};
      OFF_CTRL_B:  rd_mux = {4'h0, tx_enable_bit_q, 2'b00, ninth_q};
      OFF_CTRL_C:  rd_mux = {1'b0, cfg_q};
      OFF_BAUD_LO: rd_mux = div_q[7:0];
      OFF_BAUD_HI: rd_mux = {{(16-BAUD_WIDTH){1'b0}}, div_q[BAUD_WIDTH-1:8]};
      default:     rd_mux = 8'h00;
    endcase
  end

  always_ff @(posedge i_core_clk)
  begin
    if (i_rst) o_rdata <= 8'h00;
    else if (i_rd) o_rdata <= rd_mux;
    else o_rdata <= 8'h00;
  end

  // Checks on the frame and the flags.
  sequence s_idle_load;
    wr_data && (st_q == TX_IDLE) && !full_q && on_q;
  endsequence
  sequence s_frame_starts;
    (st_q == TX_IDLE) ##1 (st_q == TX_START);
  endsequence

  AST_START_LOW: assert property (@(posedge i_core_clk) disable iff (i_rst)
    (st_q == TX_START) |=> !o_txd) else $error("Start bit not low.");
  AST_STOP_HIGH: assert property (@(posedge i_core_clk) disable iff (i_rst)
    (st_q == TX_STOP1 || st_q == TX_STOP2) |=> o_txd) else $error("Stop bit not high.");
  AST_IDLE_HIGH: assert property (@(posedge i_core_clk) disable iff (i_rst)
    (st_q == TX_IDLE) |=> o_txd) else $error("Idle line not high.");
  AST_LSB_FIRST: assert property (@(posedge i_core_clk) disable iff (i_rst)
    (st_q == TX_START) && bit_en |=> (st_q == TX_DATA) && (idx_q == 4'h0))
    else $error("Data does not start at bit zero.");
  AST_PAR_AFTER: assert property (@(posedge i_core_clk) disable iff (i_rst)
    (st_q == TX_DATA) && bit_en && last_data && par_en |=> (st_q == TX_PAR))
    else $error("Parity bit not after last data bit.");
  AST_EMPTY_CLR: assert property (@(posedge i_core_clk) disable iff (i_rst)
    wr_data |=> full_q) else $error("Empty flag not cleared by write.");
  AST_TXC_SET: assert property (@(posedge i_core_clk) disable iff (i_rst)
    stop_end && !full_q |=> txc_q && (st_q == TX_IDLE))
    else $error("Complete flag not set at frame end.");
  AST_LOAD_START: assert property (@(posedge i_core_clk) disable iff (i_rst)
    s_idle_load |=> s_frame_starts) else $error("Idle shifter not loaded at once.");
  AST_OE_HOLD: assert property (@(posedge i_core_clk) disable iff (i_rst)
    o_txd_oe && (st_q != TX_IDLE) |=> o_txd_oe) else $error("Pin released mid frame.");
  AST_PAR_VAL: assert property (@(posedge i_core_clk) disable iff (i_rst)
    load |=> (par_q == (^$past(buf_q) ^ par_odd))) else $error("Parity value wrong.");

endmodule
